//--- rtl/mou_unit.sv
// memory-op instruction unit: dma dispatch, fast memory load/store, links
//
// Functional notes
// RL1: port-one transfer enqueues one port-one command
// RL2: port-two transfer enqueues into port-two queue
// RL3: port two drops crc and silent options
// RL4: cell address from rla, memory from rsa/rsb
// RL5: increment variants only when mode bit 5
// RL6: load fetches count halfwords from rsa/rsb
// RL7: loaded halfwords go rd, rd+1, onward
// RL8: one load moves up to 16 halfwords
// RL9: link option records source of each register
// RL10: update-memory write of linked register goes back
// RL11: linked load copies first halfword to shadow
// RL12: store writes data register to rsa/rsb address
// RL13: increment variant adds 64 modulo 512
// RL14: control options sit in bits 9:5
// RL15: fast address is rsa[3:0] over rsb
// RL16: full queue stalls the transfer, never drops
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mou_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic instr_valid,
    input wire mou_pkg::mou_instr_t instr,
    output logic instr_ack,
    output mou_pkg::mou_rf_wr_t rf_wr,
    input wire logic um_valid,
    input wire logic [5:0] um_reg,
    input wire logic [15:0] um_data,
    output logic um_ready,
    output logic p1_valid,
    output mou_pkg::mou_dma_cmd_t p1_cmd,
    input wire logic p1_ready,
    output logic p2_valid,
    output mou_pkg::mou_dma_cmd_t p2_cmd,
    input wire logic p2_ready,
    output logic fm_req_valid,
    output mou_pkg::mou_fm_req_t fm_req,
    input wire logic fm_req_ready,
    input wire logic fm_rsp_valid,
    input wire logic [15:0] fm_rsp_data,
    input wire logic [15:0] fast_data,
    output logic [15:0] fast_shadow
);
    mou_pkg::mou_state_t state_reg;
    mou_pkg::mou_dma_word_t dw;
    mou_pkg::mou_fm_word_t fw;
    mou_pkg::mou_dma_cmd_t cmd;
    logic [31:0] mode_reg;
    logic [4:0] left_reg;
    logic [5:0] rd_reg;
    logic lnk_reg;
    logic first_reg;
    logic [19:0] addr_reg;
    logic um_pend_reg;
    logic [19:0] um_addr_reg;
    logic [15:0] um_data_reg;
    logic [63:0] link_v_reg;
    logic [19:0] link_a_reg [0:63];
    logic [15:0] p1_cnt_reg;
    logic [15:0] p2_cnt_reg;
    logic wr_pend_reg;
    logic [7:0] waddr_reg;
    logic plus_en;
    logic port2;
    logic auto_inc;
    logic [15:0] rla_next;
    logic s1_in_ready;
    logic s2_in_ready;
    logic instr_take;
    logic is_dma;
    logic is_ld;
    logic is_st;
    logic dispatch;
    logic s1_load;
    logic s2_load;
    logic [4:0] hw_eff;
    logic ld_rsp;
    logic ahb_go;

    // fast memory byte address from the two source operands
    function automatic logic [19:0] fm_addr(input logic [15:0] hi, input logic [15:0] lo);
        fm_addr = {hi[3:0], lo}; // [RL15]
    endfunction

    // register read mux, unmapped offsets read zero
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        reg_read = 32'h00000000;
        if (a == mou_pkg::ADDR_MODE) begin
            reg_read = mode_reg;
        end else if (a == mou_pkg::ADDR_STATUS) begin
            reg_read = {26'h0000000, state_reg, um_pend_reg, p2_valid, p1_valid};
        end else if (a == mou_pkg::ADDR_SHADOW) begin
            reg_read = {16'h0000, fast_shadow};
        end else if (a == mou_pkg::ADDR_COUNT) begin
            reg_read = {p2_cnt_reg, p1_cnt_reg};
        end
    endfunction

    assign dw = instr.word;
    assign fw = instr.word;
    assign plus_en = mode_reg[mou_pkg::MODE_PLUS_BIT];
    assign is_dma = dw.op == mou_pkg::OP_DMA;
    assign is_ld = fw.op == mou_pkg::OP_LOAD;
    assign is_st = fw.op == mou_pkg::OP_STORE;
    // pending memory updates go first; a standing ack blocks retaking the word
    assign instr_take = instr_valid && !instr_ack && state_reg == mou_pkg::S_IDLE
        && !um_pend_reg;
    // a transfer waits in place while its queue is full
    assign dispatch = instr_take && is_dma && (port2 ? s2_in_ready : s1_in_ready); // [RL16]
    assign s1_load = dispatch && !port2; // [RL1]
    assign s2_load = dispatch && port2; // [RL2]
    // counts above sixteen are clipped to sixteen
    assign hw_eff = (fw.hw > mou_pkg::HW_MAX) ? mou_pkg::HW_MAX : fw.hw; // [RL8]
    assign ld_rsp = state_reg == mou_pkg::S_LD_WAIT && fm_rsp_valid;
    assign ahb_go = hsel && hready && htrans[1];

    mou_dma_build u_build (
        .instr(instr),
        .plus_en(plus_en),
        .cmd(cmd),
        .port2(port2),
        .auto_inc(auto_inc),
        .rla_next(rla_next)
    );

    mou_cmd_slot u_slot1 (
        .clk(clk),
        .nrst(nrst),
        .in_valid(s1_load),
        .in_cmd(cmd),
        .in_ready(s1_in_ready),
        .out_valid(p1_valid),
        .out_cmd(p1_cmd),
        .out_ready(p1_ready)
    );

    mou_cmd_slot u_slot2 (
        .clk(clk),
        .nrst(nrst),
        .in_valid(s2_load),
        .in_cmd(cmd),
        .in_ready(s2_in_ready),
        .out_valid(p2_valid),
        .out_cmd(p2_cmd),
        .out_ready(p2_ready)
    );

    // sequencer and fast memory request port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= mou_pkg::S_IDLE;
            fm_req_valid <= 1'b0;
            fm_req <= '0;
            left_reg <= 5'h00;
            rd_reg <= 6'h00;
            lnk_reg <= 1'b0;
            first_reg <= 1'b0;
            addr_reg <= 20'h00000;
        end else begin
            case (state_reg)
                mou_pkg::S_IDLE: begin
                    if (um_pend_reg && !instr_ack) begin
                        // write-back of a linked register
                        state_reg <= mou_pkg::S_UM_REQ;
                        fm_req_valid <= 1'b1;
                        fm_req <= '{we: 1'b1, addr: um_addr_reg, wdata: um_data_reg}; // [RL10]
                    end else if (instr_take && is_ld && hw_eff != 5'h00) begin
                        state_reg <= mou_pkg::S_LD_REQ;
                        fm_req_valid <= 1'b1;
                        fm_req <= '{we: 1'b0, addr: fm_addr(instr.rsa_val, instr.rsb_val),
                            wdata: 16'h0000}; // [RL6]
                        addr_reg <= fm_addr(instr.rsa_val, instr.rsb_val);
                        left_reg <= hw_eff; // [RL6]
                        rd_reg <= fw.rd; // [RL7]
                        lnk_reg <= fw.link_option;
                        first_reg <= 1'b1;
                    end else if (instr_take && is_st) begin
                        state_reg <= mou_pkg::S_ST_REQ;
                        fm_req_valid <= 1'b1;
                        fm_req <= '{we: 1'b1, addr: fm_addr(instr.rsa_val, instr.rsb_val),
                            wdata: fast_data}; // [RL12]
                    end
                end
                mou_pkg::S_LD_REQ: begin
                    if (fm_req_ready) begin
                        fm_req_valid <= 1'b0;
                        state_reg <= mou_pkg::S_LD_WAIT;
                    end
                end
                mou_pkg::S_LD_WAIT: begin
                    if (fm_rsp_valid) begin
                        first_reg <= 1'b0;
                        rd_reg <= rd_reg + 6'h01; // [RL7]
                        left_reg <= left_reg - 5'h01;
                        if (left_reg == 5'h01) begin
                            state_reg <= mou_pkg::S_IDLE;
                        end else begin
                            // next halfword, one request in flight at a time
                            addr_reg <= addr_reg + mou_pkg::HW_STEP;
                            fm_req.addr <= addr_reg + mou_pkg::HW_STEP;
                            fm_req_valid <= 1'b1;
                            state_reg <= mou_pkg::S_LD_REQ;
                        end
                    end
                end
                mou_pkg::S_ST_REQ, mou_pkg::S_UM_REQ: begin
                    if (fm_req_ready) begin
                        fm_req_valid <= 1'b0;
                        state_reg <= mou_pkg::S_IDLE;
                    end
                end
                default: begin
                    state_reg <= mou_pkg::S_IDLE;
                    fm_req_valid <= 1'b0;
                end
            endcase
        end
    end

    // retire pulse: dma on enqueue, store on accept, load on last halfword
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            instr_ack <= 1'b0;
        end else begin
            instr_ack <= dispatch
                || (instr_take && !is_dma && !is_st && !(is_ld && hw_eff != 5'h00))
                || (state_reg == mou_pkg::S_ST_REQ && fm_req_ready)
                || (ld_rsp && left_reg == 5'h01);
        end
    end

    // register file write port: loaded halfwords and rla advance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rf_wr <= '0;
        end else if (ld_rsp) begin
            rf_wr <= '{we: 1'b1, addr: rd_reg, data: fm_rsp_data}; // [RL7]
        end else if (dispatch && auto_inc) begin
            rf_wr <= '{we: 1'b1, addr: {2'b00, dw.rla}, data: rla_next}; // [RL13]
        end else begin
            rf_wr.we <= 1'b0;
        end
    end

    // link valid bits; an unlinked load breaks old links
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_v_reg <= 64'h0000000000000000;
        end else if (ld_rsp) begin
            link_v_reg[rd_reg] <= lnk_reg; // [RL9]
        end
    end

    // link source addresses, data only so no reset
    always_ff @(posedge clk) begin
        if (ld_rsp && lnk_reg) begin
            link_a_reg[rd_reg] <= addr_reg; // [RL9]
        end
    end

    // shadow register takes the first linked halfword
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fast_shadow <= 16'h0000;
        end else if (ld_rsp && first_reg && lnk_reg) begin
            fast_shadow <= fm_rsp_data; // [RL11]
        end
    end

    // one-deep update-memory buffer; unlinked updates are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            um_pend_reg <= 1'b0;
            um_ready <= 1'b1;
            um_addr_reg <= 20'h00000;
            um_data_reg <= 16'h0000;
        end else if (um_valid && um_ready && link_v_reg[um_reg]) begin
            um_pend_reg <= 1'b1;
            um_ready <= 1'b0;
            um_addr_reg <= link_a_reg[um_reg]; // [RL10]
            um_data_reg <= um_data;
        end else if (state_reg == mou_pkg::S_UM_REQ && fm_req_ready) begin
            um_pend_reg <= 1'b0;
            um_ready <= 1'b1;
        end
    end

    // per-port dispatch counters for software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p1_cnt_reg <= 16'h0000;
            p2_cnt_reg <= 16'h0000;
        end else begin
            p1_cnt_reg <= p1_cnt_reg + {15'h0000, s1_load};
            p2_cnt_reg <= p2_cnt_reg + {15'h0000, s2_load};
        end
    end

    // ahb-lite slave, zero wait states, always okay
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            waddr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= ahb_go && hwrite;
            waddr_reg <= haddr[7:0];
            if (ahb_go && !hwrite) begin
                hrdata <= reg_read(haddr[7:0]);
            end
        end
    end

    // mode register written in the data phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= mou_pkg::MODE_RST;
        end else if (wr_pend_reg && waddr_reg == mou_pkg::ADDR_MODE) begin
            mode_reg <= hwdata;
        end
    end

    property p_p1_enq;
        @(posedge clk) disable iff (!nrst)
        s1_load |=> p1_valid && p1_cmd.wr == $past(instr.word[27]);
    endproperty
    a_p1_enq: assert property (p_p1_enq) else $error("port one command missing"); // [RL1]

    property p_p2_sep;
        @(posedge clk) disable iff (!nrst)
        s2_load |=> p2_valid && $stable(p1_cnt_reg);
    endproperty
    a_p2_sep: assert property (p_p2_sep) else $error("port two command misrouted"); // [RL2]

    property p_p2_opts;
        @(posedge clk) disable iff (!nrst)
        p2_valid |-> !p2_cmd.ctl.crcx && !p2_cmd.ctl.crcy && !p2_cmd.ctl.st;
    endproperty
    a_p2_opts: assert property (p_p2_opts) else $error("port two carries port one options"); // [RL3]

    property p_cba;
        @(posedge clk) disable iff (!nrst)
        s1_load |=> p1_cmd.cba == $past(instr.rla_val);
    endproperty
    a_cba: assert property (p_cba) else $error("cell buffer address wrong"); // [RL4]

    property p_no_plus;
        @(posedge clk) disable iff (!nrst)
        dispatch && !plus_en |=> !rf_wr.we;
    endproperty
    a_no_plus: assert property (p_no_plus) else $error("increment without plus mode"); // [RL5]

    property p_rla_inc;
        @(posedge clk) disable iff (!nrst)
        dispatch && auto_inc |=> rf_wr.we
            && rf_wr.data[8:0] == $past(instr.rla_val[8:0]) + mou_pkg::RLA_STEP;
    endproperty
    a_rla_inc: assert property (p_rla_inc) else $error("rla advance wrong"); // [RL13]

    property p_ld_addr;
        @(posedge clk) disable iff (!nrst)
        instr_take && is_ld && hw_eff != 5'h00 |=> fm_req_valid
            && fm_req.addr == {$past(instr.rsa_val[3:0]), $past(instr.rsb_val)};
    endproperty
    a_ld_addr: assert property (p_ld_addr) else $error("load start address wrong"); // [RL15]

    property p_ld_max;
        @(posedge clk) disable iff (!nrst)
        state_reg != mou_pkg::S_IDLE |-> left_reg <= mou_pkg::HW_MAX;
    endproperty
    a_ld_max: assert property (p_ld_max) else $error("load count above sixteen"); // [RL8]

    property p_ld_dest;
        @(posedge clk) disable iff (!nrst)
        ld_rsp |=> rf_wr.we && rf_wr.addr == $past(rd_reg) && rf_wr.data == $past(fm_rsp_data);
    endproperty
    a_ld_dest: assert property (p_ld_dest) else $error("loaded halfword misplaced"); // [RL7]

    property p_shadow;
        @(posedge clk) disable iff (!nrst)
        ld_rsp && first_reg && lnk_reg |=> fast_shadow == $past(fm_rsp_data);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not loaded"); // [RL11]

    property p_store;
        @(posedge clk) disable iff (!nrst)
        instr_take && is_st |=> fm_req_valid && fm_req.we && fm_req.wdata == $past(fast_data);
    endproperty
    a_store: assert property (p_store) else $error("store data wrong"); // [RL12]
endmodule
`default_nettype wire

//--- rtl/mou_pkg.sv
// package: instruction layouts, carriers, constants for the memory-op unit
package mou_pkg;

    // dma control field, bits 9:5 of the word
    typedef struct packed {
        logic ibi;
        logic crcx;
        logic crcy;
        logic post_operative_directive;
        logic st;
    } mou_ctl_t;

    // memory-transfer instruction word
    typedef struct packed {
        logic [2:0] op;
        logic port2;
        logic wr;
        logic [7:0] bc;
        logic [3:0] rla;
        logic [4:0] rsa;
        mou_ctl_t ctl;
        logic [4:0] rsb;
    } mou_dma_word_t;

    // fast memory load/store instruction word
    typedef struct packed {
        logic [5:0] op;
        logic [5:0] rd;
        logic link_option;
        logic [1:0] pad_a;
        logic z;
        logic pad_b;
        logic [4:0] rsa;
        logic [4:0] hw;
        logic [4:0] rsb;
    } mou_fm_word_t;

    // instruction plus operands read by the pipeline
    typedef struct packed {
        logic [31:0] word;
        logic [15:0] rla_val;
        logic [15:0] rsa_val;
        logic [15:0] rsb_val;
    } mou_instr_t;

    typedef struct packed {
        logic wr;
        logic [15:0] cba;
        logic [31:0] maddr;
        logic [7:0] bc;
        mou_ctl_t ctl;
    } mou_dma_cmd_t;

    typedef struct packed {
        logic we;
        logic [19:0] addr;
        logic [15:0] wdata;
    } mou_fm_req_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [15:0] data;
    } mou_rf_wr_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LD_REQ = 3'b001,
        S_LD_WAIT = 3'b010,
        S_ST_REQ = 3'b011,
        S_UM_REQ = 3'b100
    } mou_state_t;

    localparam logic [2:0] OP_DMA = 3'h3;
    localparam logic [5:0] OP_LOAD = 6'h20;
    localparam logic [5:0] OP_STORE = 6'h21;
    localparam int unsigned MODE_PLUS_BIT = 5;
    localparam logic [8:0] RLA_STEP = 9'h040;
    localparam logic [4:0] HW_MAX = 5'h10;
    localparam logic [19:0] HW_STEP = 20'h00002;
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SHADOW = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [31:0] MODE_RST = 32'h00000000;
endpackage

//--- rtl/mou_dma_build.sv
// dma command formation from a transfer instruction and its operands
`timescale 1ns/1ps
`default_nettype none
module mou_dma_build (
    input wire mou_pkg::mou_instr_t instr,
    input wire logic plus_en,
    output mou_pkg::mou_dma_cmd_t cmd,
    output logic port2,
    output logic auto_inc,
    output logic [15:0] rla_next
);
    mou_pkg::mou_dma_word_t dw;

    assign dw = instr.word;
    assign port2 = dw.port2;
    // bit 26 is the increment flag only in plus mode, else the bc msb
    assign auto_inc = plus_en & dw.bc[7]; // [RL5]
    // advance within a 512-byte window, upper bits kept
    assign rla_next = {instr.rla_val[15:9], instr.rla_val[8:0] + mou_pkg::RLA_STEP}; // [RL13]

    // port two carries no crc or silent-transfer options
    always_comb begin
        cmd.wr = dw.wr;
        cmd.cba = instr.rla_val; // [RL4]
        cmd.maddr = {instr.rsa_val, instr.rsb_val}; // [RL4]
        cmd.bc = plus_en ? {1'b0, dw.bc[6:0]} : dw.bc;
        cmd.ctl = dw.ctl; // [RL14]
        if (dw.port2) begin
            cmd.ctl.crcx = 1'b0; // [RL3]
            cmd.ctl.crcy = 1'b0; // [RL3]
            cmd.ctl.st = 1'b0; // [RL3]
        end
    end
endmodule
`default_nettype wire

//--- rtl/mou_cmd_slot.sv
// one-entry output stage feeding a port command queue
`timescale 1ns/1ps
`default_nettype none
module mou_cmd_slot (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire mou_pkg::mou_dma_cmd_t in_cmd,
    output logic in_ready,
    output logic out_valid,
    output mou_pkg::mou_dma_cmd_t out_cmd,
    input wire logic out_ready
);
    assign in_ready = !out_valid || out_ready;

    // entry held until the queue takes it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_cmd <= '0;
        end else if (in_valid && in_ready) begin
            out_valid <= 1'b1;
            out_cmd <= in_cmd;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    property p_slot_hold;
        @(posedge clk) disable iff (!nrst)
        out_valid && !out_ready |=> out_valid && $stable(out_cmd);
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("queued command lost"); // [RL16]

    property p_slot_room;
        @(posedge clk) disable iff (!nrst)
        in_valid |-> in_ready;
    endproperty
    a_slot_room: assert property (p_slot_room) else $error("command pushed into full slot"); // [RL16]
endmodule
`default_nettype wire

//--- verification/mou_far_model.sv
// far side model: two port command queues and a fast memory controller
`timescale 1ns/1ps
`default_nettype none
module mou_far_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hold_q,
    input wire logic p1_valid,
    input wire mou_pkg::mou_dma_cmd_t p1_cmd,
    output logic p1_ready,
    input wire logic p2_valid,
    input wire mou_pkg::mou_dma_cmd_t p2_cmd,
    output logic p2_ready,
    input wire logic fm_req_valid,
    input wire mou_pkg::mou_fm_req_t fm_req,
    output logic fm_req_ready,
    output logic fm_rsp_valid,
    output logic [15:0] fm_rsp_data
);
    mou_pkg::mou_dma_cmd_t q1[$];
    mou_pkg::mou_dma_cmd_t q2[$];
    logic [19:0] w_addr;
    logic [15:0] w_data;
    logic [19:0] rd_addr;
    logic rd_pend;
    int nw;
    // memory contents depend on the whole address, high nibble too
    function automatic logic [15:0] mem(input logic [19:0] a);
        return a[15:0] ^ {a[19:16], 12'h3a5};
    endfunction
    // queues refuse while the bench holds them full
    assign p1_ready = !hold_q;
    assign p2_ready = !hold_q;
    // keep every command taken, in order, for the bench to pop
    always @(posedge clk) begin
        if (p1_valid && p1_ready) q1.push_back(p1_cmd);
        if (p2_valid && p2_ready) q2.push_back(p2_cmd);
    end
    // slow accept every other cycle; idle read data toggles so stale use shows
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fm_req_ready <= 1'b0;
            fm_rsp_valid <= 1'b0;
            fm_rsp_data <= 16'h0000;
            rd_pend <= 1'b0;
            nw <= 0;
        end else begin
            fm_req_ready <= fm_req_valid && !fm_req_ready;
            fm_rsp_valid <= rd_pend;
            fm_rsp_data <= rd_pend ? mem(rd_addr) : ~fm_rsp_data;
            rd_pend <= fm_req_valid && fm_req_ready && !fm_req.we;
            rd_addr <= fm_req.addr;
            if (fm_req_valid && fm_req_ready && fm_req.we) begin
                w_addr <= fm_req.addr;
                w_data <= fm_req.wdata;
                nw <= nw + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/memory_op_instruction_unit_tb.sv
// self-checking bench: dma dispatch, fast memory load/store, update path
`timescale 1ns/1ps
`default_nettype none
module memory_op_instruction_unit_tb;
    logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, instr_valid, instr_ack;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    mou_pkg::mou_instr_t instr;
    mou_pkg::mou_rf_wr_t rf_wr;
    mou_pkg::mou_dma_cmd_t p1_cmd, p2_cmd;
    mou_pkg::mou_fm_req_t fm_req;
    logic um_valid, um_ready, p1_valid, p1_ready, p2_valid, p2_ready, hold_q;
    logic fm_req_valid, fm_req_ready, fm_rsp_valid;
    logic [5:0] um_reg;
    logic [15:0] um_data, fm_rsp_data, fast_data, fast_shadow;
    logic [21:0] rq[$];
    int mismatches, tests_run, n_ack;
    assign hready = hreadyout;
    mou_unit dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .instr_valid, .instr, .instr_ack, .rf_wr, .um_valid,
        .um_reg, .um_data, .um_ready, .p1_valid, .p1_cmd, .p1_ready, .p2_valid, .p2_cmd,
        .p2_ready, .fm_req_valid, .fm_req, .fm_req_ready, .fm_rsp_valid, .fm_rsp_data,
        .fast_data, .fast_shadow);
    mou_far_model far (.clk, .nrst, .hold_q, .p1_valid, .p1_cmd, .p1_ready, .p2_valid,
        .p2_cmd, .p2_ready, .fm_req_valid, .fm_req, .fm_req_ready, .fm_rsp_valid,
        .fm_rsp_data);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // log register-file writes and retirements as they land
    always @(posedge clk) begin
        if (rf_wr.we === 1'b1) rq.push_back({rf_wr.addr, rf_wr.data});
        if (instr_ack === 1'b1) n_ack++;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // single word transfer; each phase held until hready is seen high
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // offer one instruction, drop it at the ack edge, idle one cycle
    task automatic issue(input logic [31:0] w, input logic [15:0] a, input logic [15:0] s,
        input logic [15:0] b);
        instr_valid <= 1'b1;
        instr <= {w, a, s, b};
        do @(posedge clk); while (instr_ack !== 1'b1);
        instr_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial begin
        {hsel, hwrite, instr_valid, um_valid, hold_q, haddr, hwdata, htrans} = '0;
        {instr, um_reg, um_data, fast_data} = '0;
        hsize = 3'h2;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        chk("mode", r, mou_pkg::MODE_RST);
        ahb(1'b0, 32'h40, 32'h0);
        chk("unmapped", r, 32'h0);
        chk("okay", {hreadyout, hresp}, 2'b10);
        // all four directions, plus mode off: bit 26 belongs to the byte count
        for (int i = 0; i < 4; i++) begin
            issue({3'b011, i[1], i[0], 8'hb7, 4'h3, 5'h04, 5'h1f, 5'h05}, 16'h1234, 16'h5678,
                16'h9abc);
            if (i[1]) begin
                chk("p2 cmd", far.q2.pop_front(),
                    {i[0], 16'h1234, 32'h56789abc, 8'hb7, 5'h12});
            end else begin
                chk("p1 cmd", far.q1.pop_front(),
                    {i[0], 16'h1234, 32'h56789abc, 8'hb7, 5'h1f});
            end
        end
        chk("extra cmds", far.q1.size() + far.q2.size() + rq.size(), 0);
        $display("dma test done");
        ahb(1'b1, 32'h0, 32'h20);
        ahb(1'b0, 32'h0, 32'h0);
        chk("mode", r, 32'h20);
        issue({3'b011, 2'b00, 8'h85, 4'h3, 5'h04, 5'h1f, 5'h05}, 16'ha5f0, 16'h1, 16'h2);
        chk("plus cmd", far.q1.pop_front(), {1'b0, 16'ha5f0, 32'h10002, 8'h05, 5'h1f});
        chk("rla step", rq.pop_front(), {6'h03, 16'ha430});
        // a full queue holds the next transfer back without losing it
        hold_q <= 1'b1;
        issue({3'b011, 2'b10, 8'h01, 4'h1, 15'h0}, 16'h11, 16'h0, 16'h0);
        fork
            issue({3'b011, 2'b11, 8'h02, 4'h1, 15'h0}, 16'h22, 16'h0, 16'h0);
            begin
                r = n_ack;
                repeat (20) @(posedge clk);
                chk("stall ack", n_ack, r);
                hold_q <= 1'b0;
            end
        join
        chk("first", far.q2.pop_front(), {1'b0, 16'h11, 32'h0, 8'h01, 5'h0});
        chk("second", far.q2.pop_front(), {1'b1, 16'h22, 32'h0, 8'h02, 5'h0});
        $display("plus and stall test done");
        // linked sixteen-halfword load, then write-back of one linked register
        issue({mou_pkg::OP_LOAD, 6'h10, 1'b1, 4'h0, 5'h0, 5'h10, 5'h0}, 16'h0, 16'hfff3, 16'h1000);
        for (int i = 0; i < 16; i++) begin
            chk("load", rq.pop_front(),
                {6'h10 + 6'(i), (16'h1000 + 16'(2 * i)) ^ 16'h33a5});
        end
        chk("shadow", fast_shadow, 16'h1000 ^ 16'h33a5);
        um_valid <= 1'b1;
        um_reg <= 6'h11;
        um_data <= 16'h7e57;
        do @(posedge clk); while (um_ready !== 1'b1);
        um_valid <= 1'b0;
        do @(posedge clk); while (far.nw == 0);
        chk("um addr", far.w_addr, 20'h31002);
        chk("um data", far.w_data, 16'h7e57);
        $display("load test done");
        fast_data <= 16'h1dea;
        issue({mou_pkg::OP_STORE, 26'h0}, 16'h0, 16'h0009, 16'h2468);
        chk("store addr", far.w_addr, 20'h92468);
        chk("store data", far.w_data, 16'h1dea);
        chk("writes", far.nw, 2);
        ahb(1'b0, 32'hc, 32'h0);
        chk("count", r, 32'h00040003);
        $display("store test done");
        close_out;
    end
endmodule
`default_nettype wire
